// >>> hdl/window_watchdog_timer.sv
// Window watchdog timer with APB registers, fuse defaults, lock and window mode.
// Functional notes
// - Timeout without restart requests system reset.
// - Accepted restart clears counter, new period.
// - Normal mode accepts restart any time.
// - Window restart in closed period resets.
// - Open period follows the closed period.
// - Open period elapsing without restart resets.
// - Counter advances on 1 kHz slow clock.
// - Keeps counting in sleep and clock failure.
// - Period code n gives 8 times 2^n.
// - Reserved period codes never time out.
// - Window mode: period field sets open length.
// - Period and enable load from fuses.
// - Control write needs change enable set.
// - Enable bit starts, clearing it stops.
// - Writes need open protection window.
// - Lock fuse makes control register read-only.
// - After system reset, settings keep running.
// - Locked: closed period frozen, window enable writable.
// - Closed period field, same encoding, fuse default.
// - Window enable changes only with its change enable.
// - Busy flag until settings reach slow domain.
//
// Design decision made here: the APB slave port.
`include "wdt_map.svh"

module window_watchdog_timer (
  input  wire logic               clock_i,
  input  wire logic               arst_n_i,
  // APB slave.
  input  wire wdt_pkg::apb_addr_t paddr_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [31:0]        pwdata_i,
  input  wire logic [3:0]         pstrb_i,
  output logic [31:0]             prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // CPU restart pulse and protection qualifier.
  input  wire logic               watchdog_restart_instruction_i,
  input  wire logic               protection_open_i,
  // Slow oscillator and fuses.
  input  wire logic               slow_oscillator_1khz_i,
  input  wire logic               lock_fuse_i,
  input  wire wdt_pkg::period_code_t default_period_fuse_i,
  input  wire logic               default_enable_fuse_i,
  input  wire wdt_pkg::period_code_t default_closed_fuse_i,
  input  wire logic               default_window_fuse_i,
  // Request to the system reset controller.
  output logic                    reset_request_o
);
  import wdt_pkg::*;

  // Converts a period code to its slow-cycle count; zero means no timeout.
  function automatic count_t code_cycles(input period_code_t code);
    count_t cycles;
    cycles = `WDT_CNT_ZERO;
    if (code <= `WDT_CODE_MAX) begin
      cycles = count_t'(`WDT_BASE_CYCLES << code);
    end else begin
      cycles = `WDT_CNT_ZERO;
    end
    return cycles;
  endfunction

  // Software-visible settings.
  period_code_t per_q;        // Open or single timeout period code.
  logic         en_q;         // Enable bit.
  period_code_t closed_period_select_q;       // Closed period code.
  logic         wen_q;        // Window mode enable bit.
  // Settings as used by the slow-domain counter.
  period_code_t act_per_q;
  logic         act_en_q;
  period_code_t act_closed_period_select_q;
  logic         act_wen_q;
  // Housekeeping state.
  logic         loaded_q;     // Fuses have been copied in.
  logic         pend_q;       // Settings waiting for the next slow tick.
  logic         rst_pend_q;   // Restart waiting for the next slow tick.
  count_t       cnt_q;        // Slow cycles counted in this phase.
  phase_e       phase_q;      // Current phase.
  logic         reset_request_q;
  logic [31:0]  prdata_q;
  logic         pready_q;
  logic         pslverr_q;

  // Next values.
  period_code_t per_d;
  logic         en_d;
  period_code_t closed_period_select_d;
  logic         wen_d;
  logic         pend_d;
  logic         rst_pend_d;
  count_t       cnt_d;
  phase_e       phase_d;
  logic         fire_d;
  logic [31:0]  prdata_d;

  // Slow clock tick from the oscillator edge detector.
  wire logic tick;

  slow_tick_detect u_tick (
    .clock_i                (clock_i),
    .arst_n_i               (arst_n_i),
    .slow_oscillator_1khz_i (slow_oscillator_1khz_i),
    .tick_o                 (tick)
  );

  // Address decoding.
  wire logic hit_ctrl;
  wire logic hit_win;
  wire logic hit_stat;
  wire logic hit_any;

  assign hit_ctrl = (paddr_i == `WDT_CTRL_ADDR);
  assign hit_win  = (paddr_i == `WDT_WIN_ADDR);
  assign hit_stat = (paddr_i == `WDT_STAT_ADDR);
  assign hit_any  = hit_ctrl | hit_win | hit_stat;

  // The first access cycle prepares the answer; the write lands at the pready edge.
  wire logic acc_first;
  wire logic wr_fire;

  assign acc_first = psel_i & penable_i & ~pready_q;
  assign wr_fire   = psel_i & penable_i & pready_q & pwrite_i & pstrb_i[`WDT_LANE0_BIT];

  // A control write is discarded without protection, without change enable, or when locked.
  wire logic ctrl_wr_ok;
  wire logic win_wr_ok;

  assign ctrl_wr_ok = wr_fire & hit_ctrl & protection_open_i
                    & pwdata_i[`WDT_CEN_BIT]
                    & ~lock_fuse_i;
  assign win_wr_ok  = wr_fire & hit_win & protection_open_i
                    & pwdata_i[`WDT_CEN_BIT];

  // Next settings; fuses are taken once right after reset release.
  assign per_d  = !loaded_q  ? default_period_fuse_i
                : ctrl_wr_ok ? pwdata_i[`WDT_PER_MSB:`WDT_PER_LSB]
                : per_q;
  assign en_d   = !loaded_q  ? default_enable_fuse_i
                : ctrl_wr_ok ? pwdata_i[`WDT_EN_BIT]
                : en_q;
  assign closed_period_select_d = !loaded_q  ? default_closed_fuse_i
                : (win_wr_ok & ~lock_fuse_i) ? pwdata_i[`WDT_PER_MSB:`WDT_PER_LSB]
                : closed_period_select_q;
  assign wen_d  = !loaded_q  ? default_window_fuse_i
                : win_wr_ok  ? pwdata_i[`WDT_EN_BIT]
                : wen_q;

  // Settings cross to the counter at a slow tick while running, at once otherwise.
  wire logic cfg_write;
  wire logic needs_sync;
  wire logic apply;

  assign cfg_write  = ctrl_wr_ok | win_wr_ok;
  assign needs_sync = en_q | en_d;
  assign apply      = !loaded_q | (cfg_write & ~needs_sync) | (pend_q & tick);

  // Busy flag: a write during the tick cycle keeps it set for one more tick, so no update is lost.
  always_comb begin
    if (!loaded_q) begin
      pend_d = 1'b0;
    end else if (cfg_write & needs_sync) begin
      pend_d = 1'b1;
    end else if (tick) begin
      pend_d = 1'b0;
    end else begin
      pend_d = pend_q;
    end
  end

  // Phase limits from the active codes.
  wire count_t open_lim;
  wire count_t closed_lim;
  wire count_t cnt_inc;
  wire phase_e start_phase;

  assign open_lim    = code_cycles(act_per_q);
  assign closed_lim  = code_cycles(act_closed_period_select_q);
  assign cnt_inc     = count_t'(cnt_q + `WDT_CNT_ONE);
  assign start_phase = act_wen_q ? PH_CLOSED : PH_OPEN;

  // A restart inside the closed phase is a fault caught at once, not at the next tick.
  wire logic closed_fault;

  assign closed_fault = watchdog_restart_instruction_i & act_en_q & act_wen_q
                      & (phase_q == PH_CLOSED);

  // Pending restart; one arriving in the tick cycle is kept for the next tick.
  always_comb begin
    if (closed_fault | ~act_en_q) begin
      rst_pend_d = 1'b0;
    end else if (watchdog_restart_instruction_i) begin
      rst_pend_d = 1'b1;
    end else if (tick) begin
      rst_pend_d = 1'b0;
    end else begin
      rst_pend_d = rst_pend_q;
    end
  end

  // Phase and counter machine; the count advances only on slow ticks, while a closed fault or disable acts at once.
  // A limit lowered in mid-phase ends the phase at the next tick rather than after a counter wrap.
  always_comb begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    fire_d  = 1'b0;
    if (!act_en_q) begin
      phase_d = PH_IDLE;
      cnt_d   = `WDT_CNT_ZERO;
    end else if (closed_fault) begin
      fire_d  = 1'b1;
      phase_d = start_phase;
      cnt_d   = `WDT_CNT_ZERO;
    end else begin
      case (phase_q)
        PH_IDLE: begin
          phase_d = start_phase;
          cnt_d   = `WDT_CNT_ZERO;
        end
        PH_CLOSED: begin
          if (!act_wen_q) begin
            phase_d = PH_OPEN;
          end else if (tick) begin
            // Reaching or passing the limit both count, so a new shorter setting cannot be skipped.
            if ((closed_lim != `WDT_CNT_ZERO) && (cnt_inc >= closed_lim)) begin
              phase_d = PH_OPEN;
              cnt_d   = `WDT_CNT_ZERO;
            end else if (closed_lim != `WDT_CNT_ZERO) begin
              cnt_d = cnt_inc;
            end
          end
        end
        PH_OPEN: begin
          if (tick) begin
            if (rst_pend_q) begin
              phase_d = start_phase;
              cnt_d   = `WDT_CNT_ZERO;
            // The count may already be past a freshly lowered limit; it still times out.
            end else if ((open_lim != `WDT_CNT_ZERO) && (cnt_inc >= open_lim)) begin
              fire_d  = 1'b1;
              phase_d = start_phase;
              cnt_d   = `WDT_CNT_ZERO;
            end else if (open_lim != `WDT_CNT_ZERO) begin
              cnt_d = cnt_inc;
            end
          end
        end
        default: begin
          phase_d = PH_IDLE;
          cnt_d   = `WDT_CNT_ZERO;
        end
      endcase
    end
  end

  // Read data; reserved bits and the change enable bits read as zero.
  always_comb begin
    prdata_d = `WDT_DATA_ZERO;
    if (hit_ctrl) begin
      prdata_d = {`WDT_PAD_HIGH, `WDT_PAD_RSVD, per_q, en_q, 1'b0};
    end else if (hit_win) begin
      prdata_d = {`WDT_PAD_HIGH, `WDT_PAD_RSVD, closed_period_select_q, wen_q, 1'b0};
    end else if (hit_stat) begin
      prdata_d = {`WDT_PAD_STAT, pend_q};
    end else begin
      prdata_d = `WDT_DATA_ZERO;
    end
  end

  // Software settings; the block's own reset is power-on only, so a system reset keeps them.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      per_q    <= `WDT_PER_RST;
      en_q     <= `WDT_BIT_RST;
      closed_period_select_q   <= `WDT_PER_RST;
      wen_q    <= `WDT_BIT_RST;
      loaded_q <= 1'b0;
      pend_q   <= 1'b0;
    end else begin
      per_q    <= per_d;
      en_q     <= en_d;
      closed_period_select_q   <= closed_period_select_d;
      wen_q    <= wen_d;
      loaded_q <= 1'b1;
      pend_q   <= pend_d;
    end
  end

  // Settings as seen by the counter.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_per_q  <= `WDT_PER_RST;
      act_en_q   <= `WDT_BIT_RST;
      act_closed_period_select_q <= `WDT_PER_RST;
      act_wen_q  <= `WDT_BIT_RST;
    end else if (apply) begin
      act_per_q  <= per_d;
      act_en_q   <= en_d;
      act_closed_period_select_q <= closed_period_select_d;
      act_wen_q  <= wen_d;
    end
  end

  // Counter, phase and reset request.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q           <= `WDT_CNT_ZERO;
      phase_q         <= PH_IDLE;
      rst_pend_q      <= 1'b0;
      reset_request_q <= 1'b0;
    end else begin
      cnt_q           <= cnt_d;
      phase_q         <= phase_d;
      rst_pend_q      <= rst_pend_d;
      reset_request_q <= fire_d;
    end
  end

  // APB answer: one wait cycle, then pready with data or error for unmapped addresses.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `WDT_DATA_ZERO;
    end else begin
      pready_q  <= acc_first;
      pslverr_q <= acc_first & ~hit_any;
      prdata_q  <= (acc_first & ~pwrite_i) ? prdata_d : `WDT_DATA_ZERO;
    end
  end

  assign prdata_o        = prdata_q;
  assign pready_o        = pready_q;
  assign pslverr_o       = pslverr_q;
  assign reset_request_o = reset_request_q;

endmodule

// >>> hdl/wdt_map.svh
// Register offsets, field positions, reset values and counts of the window watchdog timer.
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Byte addresses of the three register words on the APB bus.
`define WDT_ADDR_W        12
`define WDT_CTRL_ADDR     12'h000
`define WDT_WIN_ADDR      12'h004
`define WDT_STAT_ADDR     12'h008

// Field positions of the control and window control registers, the status busy bit and the write strobe lane.
`define WDT_PER_MSB       5
`define WDT_PER_LSB       2
`define WDT_EN_BIT        1
`define WDT_CEN_BIT       0
`define WDT_BUSY_BIT      0
`define WDT_LANE0_BIT     0

// Reset values held until the fuses are loaded after reset release.
`define WDT_PER_RST       4'h0
`define WDT_BIT_RST       1'b0

// Timeout encoding: the base count is shifted left by the period code.
`define WDT_CNT_W         14
`define WDT_BASE_CYCLES   14'h0008
`define WDT_CNT_ZERO      14'h0000
`define WDT_CNT_ONE       14'h0001
`define WDT_CODE_MAX      4'ha

// Constant data words for reads.
`define WDT_DATA_ZERO     32'h0000_0000
`define WDT_PAD_HIGH      24'h00_0000
`define WDT_PAD_RSVD      2'h0
`define WDT_PAD_STAT      31'h0000_0000

`endif

// >>> hdl/wdt_pkg.sv
// Types shared by the window watchdog timer design files.
`include "wdt_map.svh"

package wdt_pkg;

  // Four-bit period code as written by software or set by fuses.
  typedef logic [3:0] period_code_t;

  // Slow-clock cycle count within one phase.
  typedef logic [`WDT_CNT_W-1:0] count_t;

  // APB address.
  typedef logic [`WDT_ADDR_W-1:0] apb_addr_t;

  // Phase of the watchdog cycle, one-hot.
  typedef enum logic [2:0] {
    PH_IDLE   = 3'b001,
    PH_CLOSED = 3'b010,
    PH_OPEN   = 3'b100
  } phase_e;

endpackage

// >>> hdl/slow_tick_detect.sv
// Turns the rising edge of the 1 kHz slow oscillator into a one-cycle tick.
module slow_tick_detect (
  input  wire logic clock_i,
  input  wire logic arst_n_i,
  input  wire logic slow_oscillator_1khz_i,
  output logic      tick_o
);

  // Previous level of the slow oscillator.
  logic prev_q;
  // Registered tick pulse.
  logic tick_q;
  // Rising edge seen this cycle.
  wire logic rise;

  assign rise = slow_oscillator_1khz_i & ~prev_q;

  // Edge detector; the tick is registered so it leaves as a clean pulse.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      prev_q <= slow_oscillator_1khz_i;
      tick_q <= rise;
    end
  end

  assign tick_o = tick_q;

endmodule

// >>> testbench/wdt_far_side_model.sv
// Far side model: slow oscillator source and system reset controller counting requests.
module wdt_far_side_model (
  input  wire logic clock_i,
  input  wire logic arst_n_i,
  input  wire logic reset_request_i,
  output logic      slow_osc_o,
  output int        req_count_o
);
  logic [2:0] div_q; // Divider making a fast stand-in for the slow oscillator.
  // The oscillator runs free with a period of eight system clocks, so tick spacing is exact.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) div_q <= 3'h0;
    else div_q <= div_q + 3'h1;
  end
  assign slow_osc_o = div_q[2];
  // Each one-cycle request is one system reset; the block itself keeps running through it.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) req_count_o <= 0;
    else if (reset_request_i) req_count_o <= req_count_o + 1;
  end
endmodule

// >>> testbench/wdt_assertions.sv
// Port-level checker of the window watchdog timer, bound to its top module.
module wdt_assertions (
  input wire logic               clock_i,
  input wire logic               arst_n_i,
  input wire wdt_pkg::apb_addr_t paddr_i,
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic [31:0]        prdata_o,
  input wire logic               pready_o,
  input wire logic               pslverr_o,
  input wire logic               watchdog_restart_instruction_i,
  input wire logic               slow_oscillator_1khz_i,
  input wire logic               reset_request_o
);
  logic [3:0] quiet_q; // Cycles since the last slow edge or restart, saturating.
  // A reset request needs a recent cause: a slow tick or a restart pulse.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) quiet_q <= 4'h0;
    else if ($rose(slow_oscillator_1khz_i) || watchdog_restart_instruction_i) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("no answer");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
  a_err_unmapped: assert property (pready_o && paddr_i > 12'h008 |-> pslverr_o) else $error("no error");
  a_err_mapped: assert property (pready_o && paddr_i == 12'h000 |-> !pslverr_o) else $error("bad error");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000) else $error("stray data");
  a_rsvd_zero: assert property (pready_o |-> prdata_o[31:6] == 26'h000_0000) else $error("bits set");
  a_rst_pulse: assert property (reset_request_o |=> !reset_request_o) else $error("long reset");
  a_rst_cause: assert property (reset_request_o |-> quiet_q < 4'h6) else $error("reset no cause");
endmodule
bind window_watchdog_timer wdt_assertions chk (.clock_i(clock_i), .arst_n_i(arst_n_i), .paddr_i(paddr_i),
  .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .watchdog_restart_instruction_i(watchdog_restart_instruction_i),
  .slow_oscillator_1khz_i(slow_oscillator_1khz_i), .reset_request_o(reset_request_o));

// >>> testbench/tb_window_watchdog_timer.sv
// Self-checking testbench of the window watchdog timer.
module tb_window_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import wdt_pkg::*;
  logic        clock_i, arst_n_i, psel, penable, pwrite, restart, prot, lock, pready, pslverr, req, slow;
  logic        fen, fwin, err;
  logic [3:0]  pstrb;
  period_code_t fper, fcl;
  apb_addr_t   paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch, checked, nreq, n, c;
  window_watchdog_timer dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .watchdog_restart_instruction_i(restart),
    .protection_open_i(prot), .slow_oscillator_1khz_i(slow), .lock_fuse_i(lock),
    .default_period_fuse_i(fper), .default_enable_fuse_i(fen), .default_closed_fuse_i(fcl),
    .default_window_fuse_i(fwin), .reset_request_o(req));
  wdt_far_side_model far (.clock_i(clock_i), .arst_n_i(arst_n_i), .reset_request_i(req),
    .slow_osc_o(slow), .req_count_o(nreq));
  // Clock of 40 ns period.
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; the request stands until ready is sampled high, then data is taken.
  task automatic apb(input logic w, input apb_addr_t a, input logic [31:0] d);
    @(posedge clock_i) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clock_i) penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input apb_addr_t a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  // Cycles from now until the next reset request.
  task automatic gap(output int k);
    k = 0;
    do begin @(posedge clock_i); k++; end while (req !== 1'b1);
  endtask
  task automatic kick();
    @(posedge clock_i) restart <= 1'b1;
    @(posedge clock_i) restart <= 1'b0;
  endtask
  task automatic t_fuse();
    rdc(12'h000, 32'h0000_0006);
    rdc(12'h004, 32'h0000_0008);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check(err, 1'b1);
  endtask
  // Interval between unattended requests is 8 << code ticks of eight clocks each.
  task automatic t_period();
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 12'h000, (k << 2) | 32'h3);
      gap(n);
      gap(n);
      check(n, (8 << k) * 8);
    end
  endtask
  // The count is taken one edge after the request, once the partner has counted it.
  task automatic t_restart();
    gap(n);
    @(posedge clock_i);
    c = nreq;
    repeat (8) begin repeat (40) @(posedge clock_i); kick(); end
    check(nreq, c);
  endtask
  // Writes lacking change enable, protection or unlock leave the control word as it was.
  task automatic t_guard();
    apb(1'b1, 12'h000, 32'h0000_0008);
    rdc(12'h000, 32'h0000_000A);
    prot <= 1'b0;
    apb(1'b1, 12'h000, 32'h0000_0009);
    rdc(12'h000, 32'h0000_000A);
    prot <= 1'b1;
    apb(1'b1, 12'h004, 32'h0000_000E);
    rdc(12'h004, 32'h0000_0008);
    lock <= 1'b1;
    apb(1'b1, 12'h000, 32'h0000_0009);
    rdc(12'h000, 32'h0000_000A);
    apb(1'b1, 12'h004, 32'h0000_000F);
    rdc(12'h004, 32'h0000_000A);
    apb(1'b1, 12'h004, 32'h0000_0001);
    lock <= 1'b0;
  endtask
  task automatic t_disable();
    apb(1'b1, 12'h000, 32'h0000_0001);
    c = nreq;
    repeat (300) @(posedge clock_i);
    check(nreq, c);
    apb(1'b1, 12'h000, 32'h0000_002F);
    repeat (300) @(posedge clock_i);
    check(nreq, c);
  endtask
  // Aligned to a slow edge, the busy flag is read before and after the tick that clears it.
  task automatic t_window();
    do @(posedge clock_i); while (slow !== 1'b0);
    do @(posedge clock_i); while (slow !== 1'b1);
    apb(1'b1, 12'h000, 32'h0000_0003);
    rdc(12'h008, 32'h0000_0001);
    rdc(12'h008, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'h0000_0003);
    gap(n);
    repeat (5) @(posedge clock_i);
    kick();
    gap(n);
    check(n, 1);
    gap(n);
    gap(n);
    check(n, 128);
    repeat (90) @(posedge clock_i);
    kick();
    c = nreq;
    repeat (60) @(posedge clock_i);
    check(nreq, c);
  endtask
  // Watchdog against a hang: the whole run needs well under 20000 cycles.
  initial begin
    #800000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    {psel, penable, pwrite, restart, paddr, pwdata} = '0;
    {prot, pstrb, lock, fper, fen, fcl, fwin} = {1'b1, 4'hf, 1'b0, 4'h1, 1'b1, 4'h2, 1'b0};
    n_mismatch = 0;
    checked = 0;
    arst_n_i = 1'b0;
    repeat (10) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    t_fuse();
    t_period();
    t_restart();
    t_guard();
    t_disable();
    t_window();
    stop_test();
  end
endmodule
